// file: hw/led_grad_regs.svh
// register offsets, field positions, reset values and timing counts
`ifndef LED_GRAD_REGS_SVH
`define LED_GRAD_REGS_SVH

`define AXI_RESP_OKAY 2'b00
`define AXI_RESP_SLVERR 2'b10

`define REG_CTRL 8'h00
`define REG_PERIOD 8'h04
`define REG_STATUS 8'h08
`define REG_INT_STATUS 8'h0c
`define REG_INT_MASK 8'h10

`define CTRL_RUN_BIT 0
`define CTRL_SLEEP_BIT 1
`define CTRL_SRC_BIT 2
`define CTRL_SIDE_BIT 3
`define CTRL_LOOP_BIT 4
`define CTRL_RESET 5'h00
`define PERIOD_RESET 8'h00
`define PERIOD_UNIT_LSB 6
`define PERIOD_COUNT_MSB 5

`define EV_LOST_BIT 0
`define EV_BACK_BIT 1
`define EV_DONE_BIT 2
`define EV_RESET 3'h0

`define LAST_GRID 6'h3f
`define STEP_UNITS_DEFAULT {16'h03e8, 16'h01f4, 16'h0064, 16'h0032}

`define AXI_CLK_PERIOD_NS 4
`define EXT_CLK_NOMINAL_MHZ 20
`define EXT_CLK_TOL_PCT 15
`define MEAS_WINDOW_NS 1000
`define MEAS_WINDOW_CYC (`MEAS_WINDOW_NS / `AXI_CLK_PERIOD_NS)
`define EDGES_NOMINAL (`EXT_CLK_NOMINAL_MHZ * `MEAS_WINDOW_NS / 1000)
`define EDGES_MIN (`EDGES_NOMINAL * (100 - `EXT_CLK_TOL_PCT) / 100)
`define EDGES_MAX (`EDGES_NOMINAL * (100 + `EXT_CLK_TOL_PCT) / 100)

`endif

// file: hw/led_grad_pkg.sv
// types shared by the gradation control block
package led_grad_pkg;

    typedef enum logic [1:0] {
        MODE_HIZ = 2'b00,
        MODE_GRID0 = 2'b01,
        MODE_RUN = 2'b10,
        MODE_HOLD = 2'b11
    } grad_mode_t;

    typedef struct packed {
        logic tick;
        logic present;
    } ext_clk_status_t;

    typedef struct packed {
        logic [1:0] sync;
        logic last;
        logic tick;
        logic [7:0] win;
        logic [7:0] edges;
        logic present;
    } mon_state_t;

    typedef struct packed {
        grad_mode_t mode;
        logic [5:0] grid;
        logic [5:0] rep;
        logic [15:0] pre;
        logic [4:0] ctrl;
        logic [7:0] period;
        logic [2:0] ists;
        logic [2:0] imask;
        logic prs_d;
        logic aw_h;
        logic [7:0] aw_a;
        logic w_h;
        logic [31:0] w_d;
        logic [3:0] w_s;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
    } core_state_t;

endpackage

// file: hw/ext_clock_monitor.sv
// external gradation clock selection, edge detection and frequency check
`timescale 1ns/100ps
`default_nettype none
`include "led_grad_regs.svh"

module ext_clock_monitor (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic resonator_clk,
    input wire logic ext_clock_input,
    input wire logic source_select,
    output led_grad_pkg::ext_clk_status_t status
);
    import led_grad_pkg::*;

    localparam logic [7:0] WIN_LAST = 8'(`MEAS_WINDOW_CYC - 1);
    localparam logic [7:0] EDGE_MIN = 8'(`EDGES_MIN);
    localparam logic [7:0] EDGE_MAX = 8'(`EDGES_MAX);

    mon_state_t st;
    mon_state_t nx;
    logic rise;
    logic win_end;
    logic in_range;

    always_comb begin
        nx = st;
        // resonator pins or forced clock feed the synchroniser
        nx.sync = {st.sync[0], source_select ? ext_clock_input
                                             : resonator_clk};
        nx.last = st.sync[1];
        rise = st.sync[1] & ~st.last;
        nx.tick = rise;
        win_end = (st.win == WIN_LAST);
        in_range = (st.edges >= EDGE_MIN) && (st.edges <= EDGE_MAX);
        nx.win = win_end ? 8'h00 : st.win + 8'h01;
        if (win_end) begin
            nx.edges = {7'h00, rise};
            nx.present = in_range;
        end else if (rise && st.edges != 8'hff) begin
            nx.edges = st.edges + 8'h01;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            st <= '0;
        end else begin
            st <= nx;
        end
    end

    assign status.tick = st.tick;
    assign status.present = st.present;

    a_flag_out_range: assert property (
        @(posedge aclk) disable iff (!aresetn)
        (win_end && !in_range) |=> !status.present)
        else $error("present flag not cleared for out-of-range clock");

    a_flag_back_in: assert property (
        @(posedge aclk) disable iff (!aresetn)
        (win_end && in_range) |=> status.present)
        else $error("present flag not restored for in-range clock");

endmodule
`default_nettype wire

// file: hw/led_grad_ctrl.sv
// gradation output control with AXI4-Lite registers and clock supervision
// Functional notes
// - aclk runs control; external clock times steps
// - control bit picks resonator or forced clock
// - present flag clears beyond fifteen percent deviation
// - present flag is informational; gradation continues
// - no external clock holds current grid
// - start when output enable low and run
// - output enable high forces high impedance
// - sleep hiz osc off; idle grid0; run
// - side bit selects register side for writes
// - step duration from unit and count fields
`timescale 1ns/100ps
`default_nettype none
`include "led_grad_regs.svh"

module led_grad_ctrl #(
    parameter logic [63:0] STEP_UNITS = `STEP_UNITS_DEFAULT
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic oe_n,
    input wire logic resonator_clk,
    input wire logic ext_clock_input,
    output logic led_hiz,
    output logic osc_enable,
    output logic [5:0] grid_index,
    output logic gradation_active,
    output logic write_side,
    output logic irq
);
    import led_grad_pkg::*;

    core_state_t st;
    core_state_t nx;
    ext_clk_status_t ext;
    logic [15:0] unit_len;
    logic [5:0] step_count;
    logic hiz_req;
    logic run_req;
    logic wr_fire;
    logic wr_hit;
    logic [7:0] wr_addr;
    logic [7:0] rd_addr;
    logic [2:0] ev;
    logic [2:0] clr;

    ext_clock_monitor u_mon (
        .aclk(aclk),
        .aresetn(aresetn),
        .resonator_clk(resonator_clk),
        .ext_clock_input(ext_clock_input),
        .source_select(st.ctrl[`CTRL_SRC_BIT]),
        .status(ext)
    );

    assign s_axi_awready = !st.aw_h;
    assign s_axi_wready = !st.w_h;
    assign s_axi_bvalid = st.bvalid;
    assign s_axi_bresp = st.bresp;
    assign s_axi_arready = !st.rvalid;
    assign s_axi_rvalid = st.rvalid;
    assign s_axi_rdata = st.rdata;
    assign s_axi_rresp = st.rresp;

    always_comb begin
        nx = st;
        ev = 3'h0;
        clr = 3'h0;
        unit_len = STEP_UNITS[{st.period[7:6], 4'h0} +: 16];
        step_count = st.period[`PERIOD_COUNT_MSB:0];
        // hiz whenever enable is high or sleep is set
        hiz_req = oe_n || st.ctrl[`CTRL_SLEEP_BIT];
        run_req = st.ctrl[`CTRL_RUN_BIT];
        wr_addr = {st.aw_a[7:2], 2'b00};
        rd_addr = {s_axi_araddr[7:2], 2'b00};
        wr_fire = st.aw_h && st.w_h && !st.bvalid;
        wr_hit = 1'b0;

        // write channel: address and data taken in either order
        if (s_axi_awvalid && !st.aw_h) begin
            nx.aw_h = 1'b1;
            nx.aw_a = s_axi_awaddr;
        end
        if (s_axi_wvalid && !st.w_h) begin
            nx.w_h = 1'b1;
            nx.w_d = s_axi_wdata;
            nx.w_s = s_axi_wstrb;
        end
        if (st.bvalid && s_axi_bready) begin
            nx.bvalid = 1'b0;
        end
        if (wr_fire) begin
            nx.aw_h = 1'b0;
            nx.w_h = 1'b0;
            nx.bvalid = 1'b1;
            unique case (wr_addr)
                `REG_CTRL: begin
                    wr_hit = 1'b1;
                    // side bit steers later grid and channel writes
                    if (st.w_s[0]) begin
                        nx.ctrl = st.w_d[4:0];
                    end
                end
                `REG_PERIOD: begin
                    wr_hit = 1'b1;
                    if (st.w_s[0]) begin
                        nx.period = st.w_d[7:0];
                    end
                end
                `REG_STATUS: begin
                    wr_hit = 1'b1;
                end
                `REG_INT_STATUS: begin
                    wr_hit = 1'b1;
                    if (st.w_s[0]) begin
                        clr = st.w_d[2:0];
                    end
                end
                `REG_INT_MASK: begin
                    wr_hit = 1'b1;
                    if (st.w_s[0]) begin
                        nx.imask = st.w_d[2:0];
                    end
                end
                default: begin
                    wr_hit = 1'b0;
                end
            endcase
            nx.bresp = wr_hit ? `AXI_RESP_OKAY : `AXI_RESP_SLVERR;
        end

        // read channel
        if (st.rvalid && s_axi_rready) begin
            nx.rvalid = 1'b0;
        end
        if (s_axi_arvalid && !st.rvalid) begin
            nx.rvalid = 1'b1;
            nx.rresp = `AXI_RESP_OKAY;
            unique case (rd_addr)
                `REG_CTRL: begin
                    nx.rdata = {27'h0000000, st.ctrl};
                end
                `REG_PERIOD: begin
                    nx.rdata = {24'h000000, st.period};
                end
                `REG_STATUS: begin
                    // flag already resynchronised to aclk
                    nx.rdata = {18'h00000, st.grid, 5'h00, st.mode,
                                ext.present};
                end
                `REG_INT_STATUS: begin
                    nx.rdata = {29'h00000000, st.ists};
                end
                `REG_INT_MASK: begin
                    nx.rdata = {29'h00000000, st.imask};
                end
                default: begin
                    nx.rdata = 32'h00000000;
                    nx.rresp = `AXI_RESP_SLVERR;
                end
            endcase
        end

        // output mode sequencing
        if (hiz_req) begin
            nx.mode = MODE_HIZ;
            nx.grid = 6'h00;
            nx.rep = 6'h00;
            nx.pre = 16'h0000;
        end else if (!run_req) begin
            nx.mode = MODE_GRID0;
            nx.grid = 6'h00;
            nx.rep = 6'h00;
            nx.pre = 16'h0000;
        end else begin
            unique case (st.mode)
                MODE_HIZ, MODE_GRID0: begin
                    // start once both enable low and run set
                    nx.mode = MODE_RUN;
                    nx.grid = 6'h00;
                    nx.rep = 6'h00;
                    nx.pre = 16'h0000;
                end
                MODE_RUN: begin
                    // steps advance only on external clock edges
                    if (ext.tick) begin
                        if (st.pre >= unit_len - 16'h0001) begin
                            nx.pre = 16'h0000;
                            if (st.rep == step_count) begin
                                nx.rep = 6'h00;
                                if (st.grid == `LAST_GRID) begin
                                    ev[`EV_DONE_BIT] = 1'b1;
                                    if (st.ctrl[`CTRL_LOOP_BIT]) begin
                                        nx.grid = 6'h00;
                                    end else begin
                                        nx.mode = MODE_HOLD;
                                    end
                                end else begin
                                    nx.grid = st.grid + 6'h01;
                                end
                            end else begin
                                nx.rep = st.rep + 6'h01;
                            end
                        end else begin
                            nx.pre = st.pre + 16'h0001;
                        end
                    end
                end
                MODE_HOLD: begin
                    nx.mode = MODE_HOLD;
                end
            endcase
        end

        // interrupt events; a new event beats a same-cycle clear
        nx.prs_d = ext.present;
        ev[`EV_LOST_BIT] = st.prs_d && !ext.present;
        ev[`EV_BACK_BIT] = !st.prs_d && ext.present;
        nx.ists = (st.ists & ~clr) | ev;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            st <= '0;
            st.ctrl <= `CTRL_RESET;
            st.period <= `PERIOD_RESET;
            st.ists <= `EV_RESET;
            st.imask <= `EV_RESET;
        end else begin
            st <= nx;
        end
    end

    assign led_hiz = (st.mode == MODE_HIZ);
    assign osc_enable = !st.ctrl[`CTRL_SLEEP_BIT];
    assign grid_index = st.grid;
    assign gradation_active = (st.mode == MODE_RUN);
    assign write_side = st.ctrl[`CTRL_SIDE_BIT];
    assign irq = |(st.ists & st.imask);

    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    a_oe_forces_hiz: assert property (
        oe_n |=> led_hiz && grid_index == 6'h00)
        else $error("outputs not high impedance with enable high");

    a_sleep_stops_osc: assert property (
        (!oe_n && st.ctrl[`CTRL_SLEEP_BIT]) |-> !osc_enable ##1 led_hiz)
        else $error("sleep did not force hiz and oscillator off");

    a_idle_shows_grid0: assert property (
        (!oe_n && st.ctrl[1:0] == 2'b00) |=> (!led_hiz && grid_index == 6'h00
        && !gradation_active))
        else $error("idle enable did not show grid zero");

    a_start_needs_both: assert property (
        $rose(gradation_active) |-> ($past(!oe_n) && $past(run_req)
        && $past(grid_index) == 6'h00 && grid_index == 6'h00))
        else $error("gradation started without enable and run");

    a_hold_no_tick: assert property (
        (gradation_active && !ext.tick && !hiz_req && run_req)
        |=> $stable(grid_index) && gradation_active)
        else $error("grid moved without an external clock edge");

    a_flag_ignored: assert property (
        (!ext.present && st.mode == MODE_GRID0 && !hiz_req && run_req)
        |=> gradation_active)
        else $error("absent clock flag blocked gradation start");

    a_side_select: assert property (
        (wr_fire && wr_addr == `REG_CTRL && st.w_s[0])
        |=> write_side == $past(st.w_d[`CTRL_SIDE_BIT]))
        else $error("side select did not follow control write");

    a_step_duration: assert property (
        ($past(gradation_active) && gradation_active
        && grid_index != $past(grid_index))
        |-> ($past(ext.tick) && $past(st.rep) == $past(step_count)))
        else $error("grid advanced before its duration elapsed");

    a_write_answer: assert property (
        (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
        && !st.bvalid) |=> ##1 s_axi_bvalid)
        else $error("write response missing two cycles after request");

    a_read_answer: assert property (
        (s_axi_arvalid && s_axi_arready) |=> s_axi_rvalid)
        else $error("read data not valid one cycle after request");

    a_period_write: assert property (
        (wr_fire && wr_addr == `REG_PERIOD && st.w_s[0])
        |=> st.period == $past(st.w_d[7:0]))
        else $error("period register did not take written value");

    a_strobe_blocks: assert property (
        (wr_fire && !st.w_s[0]) |=> $stable(st.ctrl) && $stable(st.period))
        else $error("write without strobe changed a register");

    a_start_from_hiz: assert property (
        (st.mode == MODE_HIZ && !hiz_req && run_req) |=> gradation_active)
        else $error("gradation did not start from high impedance");

    // end of the last grid: one shot holds, recurrence wraps
    a_last_grid_hold: assert property (
        (ev[`EV_DONE_BIT] && !st.ctrl[`CTRL_LOOP_BIT])
        |=> (st.mode == MODE_HOLD && grid_index == `LAST_GRID))
        else $error("one-shot sequence did not hold the last grid");

    a_loop_restart: assert property (
        (ev[`EV_DONE_BIT] && st.ctrl[`CTRL_LOOP_BIT])
        |=> (gradation_active && grid_index == 6'h00))
        else $error("recurrence did not restart from grid zero");

    // an event in the cycle of a clear must still be seen
    a_event_sets_flag: assert property (
        (ev != 3'h0) |=> ((st.ists & $past(ev)) == $past(ev)))
        else $error("interrupt event lost against a clear");

endmodule
`default_nettype wire

// file: verif/ext_clk_source.sv
// model of the external gradation clock source
`timescale 1ns/100ps
`default_nettype none

module ext_clk_source (
    input wire logic en,
    input wire logic [7:0] half_ns,
    output logic clk
);
    // a stopped source stands low, it never free-runs
    always begin
        if (en !== 1'b1) begin
            clk = 1'b0;
            wait (en);
        end
        #(half_ns) clk = ~clk;
    end
endmodule
`default_nettype wire

// file: verif/test_led_grad_ctrl.sv
// self-checking bench for the gradation control block
`timescale 1ns/100ps
`default_nettype none
`include "led_grad_regs.svh"

module test_led_grad_ctrl;
    import led_grad_pkg::*;
    localparam logic [1:0] rsp_ok = `AXI_RESP_OKAY;
    localparam logic [1:0] rsp_err = `AXI_RESP_SLVERR;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic [7:0] awaddr = 8'h00;
    logic [31:0] wdata = 32'h0;
    logic awvalid = 1'b0;
    logic wvalid = 1'b0;
    logic [7:0] araddr = 8'h00;
    logic arvalid = 1'b0;
    logic [3:0] strb = 4'hf;
    logic oe_n = 1'b1;
    logic res_en = 1'b0;
    logic ext_en = 1'b0;
    logic [7:0] res_half = 8'h19;
    logic [7:0] ext_half = 8'h19;
    logic res_clk, ext_clk, awready, wready, bvalid, arready, rvalid;
    logic led_hiz, osc_enable, gradation_active, write_side, irq;
    logic [1:0] bresp, rresp;
    logic [31:0] rdata, rnd;
    logic [5:0] grid_index, held;
    logic [34:0] e;
    logic [34:0] exp_q[$];
    logic [7:0] halves[4] = '{8'h14, 8'h19, 8'h21, 8'h19};
    int n_errors = 0;
    int checks_done = 0;
    int seed = 99;
    int i, k;

    always #2 aclk = ~aclk;

    led_grad_ctrl #(.STEP_UNITS(64'h0004_0003_0002_0001)) DUT (
        .aclk(aclk), .aresetn(aresetn),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata),
        .s_axi_wstrb(strb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(1'b1),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(1'b1),
        .oe_n(oe_n), .resonator_clk(res_clk), .ext_clock_input(ext_clk),
        .led_hiz(led_hiz), .osc_enable(osc_enable),
        .grid_index(grid_index), .gradation_active(gradation_active),
        .write_side(write_side), .irq(irq)
    );
    ext_clk_source res_src (.en(res_en), .half_ns(res_half), .clk(res_clk));
    ext_clk_source ext_src (.en(ext_en), .half_ns(ext_half), .clk(ext_clk));

    task chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            n_errors++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task end_of_test;
        $display("checks %0d errors %0d", checks_done, n_errors);
        if (n_errors == 0 && checks_done > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    // bus tasks are entered and left just after a rising edge
    task wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
        exp_q.push_back({1'b0, r, 32'h0});
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        do begin
            @(posedge aclk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end while (!bvalid);
    endtask

    task rd(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
        exp_q.push_back({1'b1, r, d});
        araddr <= a;
        arvalid <= 1'b1;
        do begin
            @(posedge aclk);
            if (arready) arvalid <= 1'b0;
        end while (!rvalid);
    endtask

    task cyc(input int n);
        repeat (n) @(posedge aclk);
    endtask

    // answers are matched against the oldest note
    always @(posedge aclk) begin
        if (aresetn && bvalid) begin
            e = exp_q.pop_front();
            chk({31'h0, e[34]}, 32'h0);
            chk({30'h0, bresp}, {30'h0, e[33:32]});
        end
        if (aresetn && rvalid) begin
            e = exp_q.pop_front();
            chk({30'h0, rresp}, {30'h0, e[33:32]});
            chk(rdata, e[31:0]);
        end
    end

    initial begin
        #100000;
        n_errors++;
        $display("Error at %0t: run did not finish", $time);
        end_of_test;
    end

    initial begin
        cyc(5);
        aresetn <= 1'b1;
        cyc(1);
        chk(32'({led_hiz, osc_enable, gradation_active, irq}), 32'hc);
        chk(32'({write_side, grid_index}), 32'h0);
        rd(`REG_CTRL, 32'h0, rsp_ok);
        rd(`REG_INT_MASK, 32'h0, rsp_ok);
        rd(8'h40, 32'h0, rsp_err);
        wr(8'h40, 32'hf, rsp_err);
        for (k = 0; k < 4; k++) begin
            rnd = $random(seed);
            wr(`REG_PERIOD, rnd, rsp_ok);
            rd(`REG_PERIOD, {24'h0, rnd[7:0]}, rsp_ok);
        end
        // a write with its low strobe clear leaves the register alone
        strb <= 4'h0;
        wr(`REG_PERIOD, 32'hff, rsp_ok);
        strb <= 4'hf;
        rd(`REG_PERIOD, {24'h0, rnd[7:0]}, rsp_ok);
        wr(`REG_INT_MASK, 32'h3, rsp_ok);
        ext_en <= 1'b1;
        wr(`REG_CTRL, 32'h4, rsp_ok);
        cyc(600);
        rd(`REG_STATUS, 32'h1, rsp_ok);
        rd(`REG_INT_STATUS, 32'h2, rsp_ok);
        chk(32'(irq), 32'h1);
        wr(`REG_INT_STATUS, 32'h2, rsp_ok);
        cyc(2);
        chk(32'(irq), 32'h0);
        wr(`REG_CTRL, 32'h0, rsp_ok);
        cyc(600);
        rd(`REG_STATUS, 32'h0, rsp_ok);
        rd(`REG_INT_STATUS, 32'h1, rsp_ok);
        chk(32'(irq), 32'h1);
        wr(`REG_INT_MASK, 32'h0, rsp_ok);
        cyc(2);
        chk(32'(irq), 32'h0);
        wr(`REG_INT_STATUS, 32'h3, rsp_ok);
        rd(`REG_INT_STATUS, 32'h0, rsp_ok);
        res_en <= 1'b1;
        for (k = 0; k < 4; k++) begin
            res_half <= halves[k];
            cyc(600);
            rd(`REG_STATUS, 32'(k % 2), rsp_ok);
        end
        wr(`REG_CTRL, 32'h8, rsp_ok);
        chk(32'(write_side), 32'h1);
        ext_half <= 8'h14;
        wr(`REG_PERIOD, 32'h42, rsp_ok);
        wr(`REG_CTRL, 32'h5, rsp_ok);
        cyc(3);
        chk(32'({led_hiz, gradation_active}), 32'h2);
        oe_n <= 1'b0;
        cyc(4);
        chk(32'({led_hiz, gradation_active}), 32'h1);
        i = 0;
        while (grid_index !== 6'h01 && i < 2000) begin
            cyc(1);
            i++;
        end
        i = 0;
        while (grid_index !== 6'h02 && i < 2000) begin
            cyc(1);
            i++;
        end
        // six edges at 25 MHz per grid, whatever the present flag
        chk(32'(i >= 58 && i <= 62), 32'h1);
        ext_en <= 1'b0;
        cyc(20);
        held = grid_index;
        cyc(300);
        chk(32'({gradation_active, grid_index}), 32'({1'b1, held}));
        oe_n <= 1'b1;
        cyc(3);
        chk(32'({led_hiz, osc_enable, gradation_active}), 32'h6);
        wr(`REG_CTRL, 32'h4, rsp_ok);
        oe_n <= 1'b0;
        cyc(3);
        chk(32'({led_hiz, gradation_active, grid_index}), 32'h0);
        wr(`REG_CTRL, 32'h5, rsp_ok);
        cyc(3);
        chk(32'(gradation_active), 32'h1);
        wr(`REG_CTRL, 32'h6, rsp_ok);
        cyc(3);
        chk(32'({led_hiz, osc_enable, gradation_active}), 32'h4);
        oe_n <= 1'b1;
        cyc(3);
        chk(32'({led_hiz, osc_enable}), 32'h2);
        // one external edge per grid: one shot, then recurrence
        ext_en <= 1'b1;
        wr(`REG_INT_MASK, 32'h4, rsp_ok);
        wr(`REG_PERIOD, 32'h0, rsp_ok);
        wr(`REG_CTRL, 32'h5, rsp_ok);
        wr(`REG_INT_STATUS, 32'h7, rsp_ok);
        oe_n <= 1'b0;
        cyc(900);
        chk(32'({irq, led_hiz, gradation_active}), 32'h4);
        chk(32'(grid_index), 32'h3f);
        wr(`REG_CTRL, 32'h14, rsp_ok);
        wr(`REG_INT_STATUS, 32'h4, rsp_ok);
        wr(`REG_CTRL, 32'h15, rsp_ok);
        cyc(900);
        chk(32'({irq, gradation_active}), 32'h3);
        end_of_test;
    end
endmodule
`default_nettype wire
